// ---- core/srw_pkg.sv ----
// Purpose: Constants for the set/reset waveform output group
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Four channel pairs, 16-bit base timer
package srw_pkg;
    localparam int PAIRS = 4;
    localparam int CH = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_CMP0 = 8'h00;
    localparam logic [7:0] OFF_CMP_LAST = 8'h1c;
    localparam logic [7:0] OFF_CTRL0 = 8'h20;
    localparam logic [7:0] OFF_CTRL_LAST = 8'h3c;
    localparam logic [7:0] OFF_BASE_CTL_LOW = 8'h40;
    localparam logic [7:0] OFF_BASE_CTL_HIGH = 8'h44;
    localparam logic [7:0] OFF_PERIOD = 8'h48;
    localparam logic [7:0] OFF_FUNC_EN = 8'h4c;
    localparam logic [7:0] OFF_IRQ_REQ = 8'h50;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h54;
    localparam logic [7:0] OFF_TIMER = 8'h58;
    localparam logic [7:0] OFF_PINS = 8'h5c;
    // Channel control fields
    localparam int CC_INV = 0;
    localparam int CC_PRESET = 1;
    localparam int CC_WIDTH = 2;
    // Base timer control high fields
    localparam int BC_RST_CH0 = 0;
    localparam int BC_RST_SECOND = 1;
    // Base timer control low fields
    localparam int BC_RST_PERIOD = 0;
    localparam int BC_RUN = 1;
    // Reset values and timer wrap value
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    localparam logic [15:0] TIMER_WRAP = 16'hffff;
    localparam logic [7:0] REG8_RESET = 8'h00;
endpackage : srw_pkg

// ---- core/srw_pair.sv ----
// Purpose: One even/odd channel pair of the set/reset waveform generator
// Assumes: Match strobes come from the shared base timer compare
// Notes: Output level is registered in the parent's state struct
`timescale 1ns/100ps
`default_nettype none
module srw_pair (
    // Configuration
    input wire logic en_even,
    input wire logic en_odd,
    input wire logic blocked,
    input wire logic preset_level,
    input wire logic invert,
    // Matches and state
    input wire logic match_even,
    input wire logic match_odd,
    input wire logic cur_level,
    input wire logic cur_active,
    // Next values
    output logic next_level,
    output logic next_active,
    output logic pin_value
);
    logic start;
    logic stop;

    // Start when both enables set, stop when both cleared
    assign start = en_even && en_odd && !blocked;
    assign stop = !en_even && !en_odd;

    // Raw waveform: set on even match, reset on odd match
    always_comb begin
        next_active = cur_active;
        next_level = cur_level;
        if (stop || blocked) begin
            next_active = 1'b0;
            next_level = preset_level;
        end else if (!cur_active) begin
            next_level = preset_level;
            if (start) begin
                next_active = 1'b1;
            end
        end else if (match_even) begin
            next_level = 1'b1;
        end else if (match_odd) begin
            next_level = 1'b0;
        end
    end

    // Inversion applies to the generated wave
    assign pin_value = cur_level ^ invert;
endmodule // srw_pair
`default_nettype wire

// ---- core/srw_top.sv ----
// Purpose: Set/reset waveform output group with shared 16-bit base timer
// Assumes: Classic Wishbone slave on ref_clk, one base-timer tick per clock
// Notes: Waves appear only on even-channel pins
// Function
// - Without inversion the pin goes high when the timer equals the even compare value.
// - The pin goes low when the timer equals the next odd compare value.
// - With no reset selection the timer runs free over 65536 clocks.
// - Channel-0 reset selection alone clears the timer on a channel 0 match.
// - Period reset selection alone clears the timer on a period compare match.
// - A pair starts generating once both its enable bits are set.
// - A pair stops generating when both its enable bits are cleared.
// - An even compare match sets that channel's interrupt request flag when the channel's enable bit is set.
// - An odd compare match sets that channel's interrupt request flag when the channel's enable bit is set.
// - A preset bit chooses the pin level held before generation starts.
// - The inversion bit drives the pin with the complement of the wave.
// - Channel 0 reset of the timer disables the wave and the match interrupt request flags on channels 0 and 1.
// - Waves appear only on the even-channel pins.
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module srw_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Waveform pins, one per channel pair
    output logic [srw_pkg::PAIRS-1:0] waveform_out_pin,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        logic [srw_pkg::CH-1:0][15:0] cmp;
        logic [srw_pkg::CH-1:0][srw_pkg::CC_WIDTH-1:0] ctrl;
        logic [7:0] base_ctl_low;
        logic [7:0] base_ctl_high;
        logic [15:0] period;
        logic [srw_pkg::CH-1:0] func_en;
        logic [srw_pkg::CH-1:0] irq_req;
        logic [srw_pkg::CH-1:0] irq_mask;
        logic [15:0] timer;
        logic [srw_pkg::PAIRS-1:0] level;
        logic [srw_pkg::PAIRS-1:0] active;
        logic [srw_pkg::PAIRS-1:0] pins;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } srw_state_t;

    srw_state_t st;
    srw_state_t next_st;

    logic [srw_pkg::CH-1:0] match;
    logic [srw_pkg::PAIRS-1:0] pair_level;
    logic [srw_pkg::PAIRS-1:0] pair_active;
    logic [srw_pkg::PAIRS-1:0] pair_pin;
    logic rst_ch0_sel;
    logic rst_period_sel;
    logic running;
    logic req;
    logic wr;

    // Reset source decode; only a lone selection is honoured
    assign rst_ch0_sel = st.base_ctl_high[srw_pkg::BC_RST_CH0]
        && !st.base_ctl_high[srw_pkg::BC_RST_SECOND]
        && !st.base_ctl_low[srw_pkg::BC_RST_PERIOD];
    assign rst_period_sel = st.base_ctl_low[srw_pkg::BC_RST_PERIOD]
        && !st.base_ctl_high[srw_pkg::BC_RST_SECOND]
        && !st.base_ctl_high[srw_pkg::BC_RST_CH0];
    assign running = st.base_ctl_low[srw_pkg::BC_RUN];

    // Compare matches against the base timer
    always_comb begin
        for (int c = 0; c < srw_pkg::CH; c++) begin
            match[c] = running && (st.timer == st.cmp[c]);
        end
    end

    // Channel pairs
    for (genvar p = 0; p < srw_pkg::PAIRS; p++) begin : g_pair
        srw_pair u_pair (
            .en_even(st.func_en[2*p]),
            .en_odd(st.func_en[2*p+1]),
            .blocked((p == 0) && rst_ch0_sel),
            .preset_level(st.ctrl[2*p][srw_pkg::CC_PRESET]),
            .invert(st.ctrl[2*p][srw_pkg::CC_INV]),
            .match_even(match[2*p]),
            .match_odd(match[2*p+1]),
            .cur_level(st.level[p]),
            .cur_active(st.active[p]),
            .next_level(pair_level[p]),
            .next_active(pair_active[p]),
            .pin_value(pair_pin[p])
        );
    end

    assign req = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
    assign wr = req && wb_we_i;

    // Next-state logic: timer, bus, flags
    always_comb begin
        logic [7:0] a;
        logic [2:0] idx;
        logic hit;
        a = wb_adr_i;
        idx = wb_adr_i[4:2];
        hit = 1'b0;
        next_st = st;
        next_st.ack = 1'b0;
        next_st.err = 1'b0;

        // Base timer count, wrap and clear
        if (running) begin
            if ((rst_ch0_sel && match[0]) || (rst_period_sel && st.timer == st.period)) begin
                next_st.timer = srw_pkg::TIMER_RESET;
            end else begin
                next_st.timer = st.timer + 16'h0001;
            end
        end

        next_st.level = pair_level;
        next_st.active = pair_active;
        next_st.pins = pair_pin;

        // Register access
        if (req) begin
            hit = 1'b1;
            next_st.rdata = 32'h0000_0000;
            if (a >= srw_pkg::OFF_CMP0 && a <= srw_pkg::OFF_CMP_LAST) begin
                next_st.rdata = {16'h0000, st.cmp[idx]};
                if (wr && wb_sel_i[0]) next_st.cmp[idx][7:0] = wb_dat_i[7:0];
                if (wr && wb_sel_i[1]) next_st.cmp[idx][15:8] = wb_dat_i[15:8];
            end else if (a >= srw_pkg::OFF_CTRL0 && a <= srw_pkg::OFF_CTRL_LAST) begin
                next_st.rdata = {30'h0000_0000, st.ctrl[idx]};
                if (wr && wb_sel_i[0]) next_st.ctrl[idx] = wb_dat_i[srw_pkg::CC_WIDTH-1:0];
            end else begin
                case (a)
                    srw_pkg::OFF_BASE_CTL_LOW: begin
                        next_st.rdata = {24'h000000, st.base_ctl_low};
                        if (wr && wb_sel_i[0]) next_st.base_ctl_low = wb_dat_i[7:0];
                    end
                    srw_pkg::OFF_BASE_CTL_HIGH: begin
                        next_st.rdata = {24'h000000, st.base_ctl_high};
                        if (wr && wb_sel_i[0]) next_st.base_ctl_high = wb_dat_i[7:0];
                    end
                    srw_pkg::OFF_PERIOD: begin
                        next_st.rdata = {16'h0000, st.period};
                        if (wr && wb_sel_i[0]) next_st.period[7:0] = wb_dat_i[7:0];
                        if (wr && wb_sel_i[1]) next_st.period[15:8] = wb_dat_i[15:8];
                    end
                    srw_pkg::OFF_FUNC_EN: begin
                        next_st.rdata = {24'h000000, st.func_en};
                        if (wr && wb_sel_i[0]) next_st.func_en = wb_dat_i[7:0];
                    end
                    srw_pkg::OFF_IRQ_REQ: begin
                        next_st.rdata = {24'h000000, st.irq_req};
                        if (wr && wb_sel_i[0]) next_st.irq_req = st.irq_req & ~wb_dat_i[7:0];
                    end
                    srw_pkg::OFF_IRQ_MASK: begin
                        next_st.rdata = {24'h000000, st.irq_mask};
                        if (wr && wb_sel_i[0]) next_st.irq_mask = wb_dat_i[7:0];
                    end
                    srw_pkg::OFF_TIMER: begin
                        next_st.rdata = {16'h0000, st.timer};
                    end
                    srw_pkg::OFF_PINS: begin
                        next_st.rdata = {24'h000000, st.active, st.pins};
                    end
                    default: begin
                        hit = 1'b0;
                    end
                endcase
            end
            next_st.ack = hit;
            next_st.err = !hit;
        end

        // Match flags; setting wins over a clear in the same cycle
        for (int c = 0; c < srw_pkg::CH; c++) begin
            if (match[c] && st.func_en[c] && !(c < 2 && rst_ch0_sel)) begin
                next_st.irq_req[c] = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0; // All registers clear, run bit off stops the timer
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign wb_err_o = st.err;
    assign waveform_out_pin = st.pins;
    assign irq = |(st.irq_req & st.irq_mask);
endmodule // srw_top
`default_nettype wire

// ---- test/srw_asserts.sv ----
// Purpose: Port checks for srw_top
// Assumes: One clock, synchronous active-low reset
// Notes: Bus answer, reset and interrupt timing
`timescale 1ns/100ps
`default_nettype none
module srw_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [srw_pkg::PAIRS-1:0] waveform_out_pin,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // A taken request earns one answer pulse
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_ans;
        (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence
    property p_answer; s_req |=> s_ans; endproperty
    property p_idle; !(wb_cyc_i && wb_stb_i) |=> !(wb_ack_o || wb_err_o); endproperty
    property p_unmapped;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i >= 8'h60 |=> wb_err_o;
    endproperty
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_adr_i) < 8'h60; endproperty
    property p_err_one; wb_err_o |=> !wb_err_o && !wb_ack_o; endproperty
    property p_dat_hold; !wb_ack_o && !wb_err_o && $past(rst_b) |-> $stable(wb_dat_o); endproperty
    property p_rst_hold;
        disable iff (1'b0) !rst_b |=> waveform_out_pin == '0 && !irq && !wb_ack_o;
    endproperty
    property p_irq_fall; $fell(irq) |-> wb_ack_o && wb_we_i; endproperty
    a_answer: assert property (p_answer) else $error("bus answer wrong");
    a_idle: assert property (p_idle) else $error("answer without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    a_ack_cause: assert property (p_ack_cause) else $error("ack on unmapped");
    a_err_one: assert property (p_err_one) else $error("error pulse too long");
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    a_rst_hold: assert property (p_rst_hold) else $error("outputs not cleared");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule // srw_asserts
bind srw_top srw_asserts chk_u (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .waveform_out_pin, .irq);
`default_nettype wire

// ---- test/srw_load.sv ----
// Purpose: External load on the waveform pins
// Assumes: Pins sampled on ref_clk
// Notes: Counts rising edges per pin
`timescale 1ns/100ps
`default_nettype none
module srw_load (
    // Clock and pins
    input wire logic ref_clk,
    input wire logic [srw_pkg::PAIRS-1:0] waveform_out_pin,
    // Observed edges
    output logic [srw_pkg::PAIRS-1:0][15:0] rise_cnt
);
    logic [srw_pkg::PAIRS-1:0] last_lvl = '0;
    logic [srw_pkg::PAIRS-1:0][15:0] cnt = '0;
    // Count rising edges on each even-channel pin
    always @(posedge ref_clk) begin
        for (int p = 0; p < srw_pkg::PAIRS; p++) begin
            if (waveform_out_pin[p] && !last_lvl[p]) cnt[p] <= cnt[p] + 16'h0001;
        end
        last_lvl <= waveform_out_pin;
    end
    // Single driver for the observed counts
    assign rise_cnt = cnt;
endmodule // srw_load
`default_nettype wire

// ---- test/srw_tb_top.sv ----
// Purpose: Self-checking bench for srw_top
// Assumes: Classic Wishbone master, 200 MHz clock
// Notes: Short compare values keep the run brief
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; \
    if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", nm, e, g); end end
module srw_tb_top;
    logic ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, irq, last_err;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [srw_pkg::PAIRS-1:0] pins;
    logic [srw_pkg::PAIRS-1:0][15:0] rises;
    int error_cnt = 0, check_count = 0, cyc_cnt = 0, hi, lo;
    srw_top dut_u (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .waveform_out_pin(pins), .irq);
    srw_load load_u (.ref_clk, .waveform_out_pin(pins), .rise_cnt(rises));
    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 90000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One classic cycle, held until answered
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge ref_clk); while (!(wb_ack_o || wb_err_o));
        q = wb_dat_o;
        last_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask
    // High and low widths of one full cycle on a pin
    task automatic wave(input int p);
        while (pins[p] !== 1'b0) @(posedge ref_clk);
        while (pins[p] !== 1'b1) @(posedge ref_clk);
        hi = 0;
        lo = 0;
        do begin
            @(posedge ref_clk);
            hi++;
        end while (pins[p] === 1'b1);
        do begin
            @(posedge ref_clk);
            lo++;
        end while (pins[p] === 1'b0);
    endtask
    task automatic t_free();
        logic [31:0] t0;
        bus(0, 8'h58, 0);
        `CHK("timer", 32'h0, q)
        bus(0, 8'h60, 0);
        `CHK("unmapped", 1'b1, last_err)
        bus(1, 8'h08, 32'h10);
        bus(1, 8'h0c, 32'h20);
        bus(1, 8'h54, 32'h0c);
        bus(1, 8'h4c, 32'h0c);
        bus(1, 8'h40, 32'h2);
        bus(0, 8'h58, 0);
        t0 = q;
        bus(0, 8'h58, 0);
        `CHK("tick", t0 + 32'd3, q)
        wave(1);
        `CHK("high", 16, hi)
        `CHK("cycle", 65536, hi + lo)
        `CHK("irq", 1'b1, irq)
        bus(0, 8'h50, 0);
        `CHK("flags", 32'h0c, q)
        bus(1, 8'h50, 32'h0c);
        bus(1, 8'h54, 32'h0);
        `CHK("irq clear", 1'b0, irq)
        while (pins[1] !== 1'b0) @(posedge ref_clk);
        bus(0, 8'h50, 0);
        `CHK("odd flag", 32'h08, q)
        `CHK("masked", 1'b0, irq)
        `CHK("idle pins", 4'h0, pins & 4'hd)
        $display("free run test done");
    endtask
    task automatic t_period();
        bus(1, 8'h08, 32'h10);
        bus(1, 8'h0c, 32'h20);
        bus(1, 8'h48, 32'h30);
        bus(1, 8'h28, 32'h1);
        bus(1, 8'h4c, 32'h0c);
        bus(1, 8'h40, 32'h3);
        wave(1);
        `CHK("inverted high", 33, hi)
        `CHK("period", 49, hi + lo)
        $display("period test done");
    endtask
    task automatic t_ch0();
        bus(1, 8'h00, 32'h40);
        bus(1, 8'h08, 32'h10);
        bus(1, 8'h0c, 32'h20);
        bus(1, 8'h20, 32'h2);
        bus(1, 8'h30, 32'h2);
        bus(1, 8'h4c, 32'h0f);
        bus(1, 8'h44, 32'h1);
        bus(1, 8'h40, 32'h2);
        wave(1);
        `CHK("ch0 period", 65, hi + lo)
        `CHK("blocked pin", 1'b1, pins[0])
        `CHK("preset pin", 1'b1, pins[2])
        `CHK("ch0 rises", 16'h1, rises[0])
        bus(0, 8'h50, 0);
        `CHK("ch0 flags", 32'h0c, q)
        bus(1, 8'h4c, 32'h0);
        repeat (5) @(posedge ref_clk);
        hi = rises[1];
        repeat (70) @(posedge ref_clk);
        `CHK("stopped", 1'b0, pins[1])
        `CHK("no rises", hi, int'(rises[1]))
        bus(1, 8'h44, 32'h3);
        repeat (80) @(posedge ref_clk);
        bus(0, 8'h58, 0);
        `CHK("no lone reset", 1'b1, q[15:0] > 16'h0040)
        $display("channel zero test done");
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        do_reset();
        t_free();
        do_reset();
        t_period();
        do_reset();
        t_ch0();
        finish_test();
    end
endmodule // srw_tb_top
`default_nettype wire
